//--- verilog/dma_desc_map.vh
// Register offsets, field positions and reset values of the channel descriptor logic
`ifndef DMA_DESC_MAP_VH
`define DMA_DESC_MAP_VH
// Register byte offsets
`define OFF_SRC_ADDR      12'h000
`define OFF_DST_ADDR      12'h004
`define OFF_STEP          12'h008
`define OFF_MINOR_OFS     12'h00C
`define OFF_SRC_ADJ       12'h010
`define OFF_DST_ADJ       12'h014
`define OFF_ITER          12'h018
`define OFF_CTRL          12'h01C
`define OFF_STATUS        12'h020
`define OFF_CMD           12'h024
`define OFF_SG_ADDR       12'h028
// Step register fields
`define STEP_SRC_LSB      0
`define STEP_DST_LSB      16
// Minor offset register fields
`define MOFS_VAL_MSB      19
`define MOFS_DST_EN       30
`define MOFS_SRC_EN       31
// Iteration register fields
`define ITER_CUR_LSB      0
`define ITER_BEG_LSB      16
// Control register fields
`define CTRL_SMOD_LSB     0
`define CTRL_DMOD_LSB     5
`define CTRL_LINK_MODE    10
`define CTRL_LINK_CH_LSB  12
`define CTRL_AUTO_STOP    16
`define CTRL_SG_EN        17
// Status register fields
`define STAT_DONE         0
`define STAT_ERR          1
`define STAT_REQ_EN       2
`define STAT_ACTIVE       3
`define STAT_SG_BUSY      4
// Command register fields
`define CMD_SET_REQ       0
`define CMD_CLR_REQ       1
`define CMD_CLR_DONE      2
`define CMD_CLR_ERR       3
`define CMD_SW_START      4
// Link modes
`define LINK_NONE         2'h0
`define LINK_MINOR        2'h1
`define LINK_MAJOR        2'h2
// Descriptor layout
`define DESC_WORDS        8
`define SG_ALIGN_BITS     5
// Reset values
`define CTRL_RESET        32'h00010000
`define ITER_RESET        32'h00010001
`endif

//--- verilog/desc_fetch.v
// Scatter-gather descriptor fetcher over a simple memory read port
`timescale 1ns/1ns
`include "dma_desc_map.vh"
module desc_fetch #(
   parameter AW = 32
) (
   input  wire          pclk,
   input  wire          presetn,
   input  wire          start,
   input  wire [AW-1:0] base_addr,
   output reg           mem_req,
   output reg  [AW-1:0] mem_addr,
   input  wire          mem_ack,
   input  wire [31:0]   mem_rdata,
   output reg           word_valid,
   output reg  [2:0]    word_index,
   output reg  [31:0]   word_data,
   output reg           busy,
   output reg           align_error
);
   localparam ST_IDLE = 1'b0;
   localparam ST_READ = 1'b1;
   reg st;
   reg [2:0] cnt;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= ST_IDLE;
         cnt <= 3'h0;
         mem_req <= 1'b0;
         mem_addr <= {AW{1'b0}};
         word_valid <= 1'b0;
         word_index <= 3'h0;
         word_data <= 32'h00000000;
         busy <= 1'b0;
         align_error <= 1'b0;
      end else begin
         word_valid <= 1'b0;
         align_error <= 1'b0;
         case (st)
            ST_IDLE: begin
               if (start) begin
                  if (base_addr[`SG_ALIGN_BITS-1:0] != {`SG_ALIGN_BITS{1'b0}}) begin
                     align_error <= 1'b1;
                  end else begin
                     st <= ST_READ;
                     busy <= 1'b1;
                     cnt <= 3'h0;
                     mem_req <= 1'b1;
                     mem_addr <= base_addr;
                  end
               end
            end
            ST_READ: begin
               if (mem_ack) begin
                  word_valid <= 1'b1;
                  word_index <= cnt;
                  word_data <= mem_rdata;
                  if (cnt == 3'h7) begin
                     st <= ST_IDLE;
                     busy <= 1'b0;
                     mem_req <= 1'b0;
                  end else begin
                     cnt <= cnt + 3'h1;
                     mem_addr <= mem_addr + {{(AW-3){1'b0}}, 3'h4};
                  end
               end
            end
            default: st <= ST_IDLE;
         endcase
      end
   end
endmodule

//--- verilog/dma_channel_descriptor_logic.v
// One DMA channel's descriptor registers, address update, linking and scatter-gather
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "dma_desc_map.vh"
// How it works
// - Minor link triggers on each count decrement
// - Major link triggers when count exhausted
// - Misaligned next descriptor address flags error
// - Auto stop clears request enable at completion unless scatter-gather is on
// - Signed minor offset added after minor loop
// - Signed major adjustments added at completion
// - Modulo fields keep step increments in window, not offsets or adjustments
// - Scatter-gather keeps request enabled
// - Memory descriptor loads straight into registers
module dma_channel_descriptor_logic #(
   parameter CHW = 5
) (
   input  wire           pclk,
   input  wire           presetn,
   input  wire           psel,
   input  wire           penable,
   input  wire           pwrite,
   input  wire [11:0]    paddr,
   input  wire [31:0]    pwdata,
   output reg  [31:0]    prdata,
   output reg            pready,
   output reg            pslverr,
   input  wire           hw_req,
   input  wire           link_in,
   input  wire           minor_done,
   output reg            service_grant,
   output reg  [31:0]    cur_src,
   output reg  [31:0]    cur_dst,
   output reg            link_trigger,
   output reg  [CHW-1:0] link_channel,
   output reg            dma_error,
   output reg            mem_req,
   output reg  [31:0]    mem_addr,
   input  wire           mem_ack,
   input  wire [31:0]    mem_rdata
);
   // ==========================================================
   // Descriptor and control state
   reg  [31:0] src_addr;
   reg  [31:0] dst_addr;
   reg  [31:0] step;
   reg  [31:0] minor_ofs;
   reg  [31:0] src_adj;
   reg  [31:0] dst_adj;
   reg  [31:0] iter;
   reg  [31:0] ctrl;
   reg  [31:0] sg_addr;
   reg         done;
   reg         err;
   reg         req_en;
   reg         active;
   reg         fetch_start;
   wire        f_req;
   wire [31:0] f_addr;
   wire        f_valid;
   wire [2:0]  f_idx;
   wire [31:0] f_data;
   wire        f_busy;
   wire        f_aerr;

   // Modulo wrap: keep the upper bits of the base, take the low bits of the sum
   function [31:0] modulo_wrap;
      input [31:0] base;
      input [31:0] sum;
      input [4:0]  mods;
      reg   [31:0] mask;
      begin
         mask = (mods == 5'h00) ? 32'h00000000 : ~(32'hFFFFFFFF << mods);
         modulo_wrap = (mods == 5'h00) ? sum : ((base & ~mask) | (sum & mask));
      end
   endfunction

   function [31:0] sext16;
      input [15:0] v;
      begin
         sext16 = {{16{v[15]}}, v};
      end
   endfunction

   wire [15:0] cur_cnt  = iter[`ITER_CUR_LSB+15:`ITER_CUR_LSB];
   wire [31:0] mofs     = {{(31-`MOFS_VAL_MSB){minor_ofs[`MOFS_VAL_MSB]}}, minor_ofs[`MOFS_VAL_MSB:0]};
   wire [1:0]  lmode    = ctrl[`CTRL_LINK_MODE+1:`CTRL_LINK_MODE];
   // Link channel field ends below the auto stop bit
   wire [CHW-1:0] link_ch = {{(CHW-4){1'b0}}, ctrl[`CTRL_LINK_CH_LSB+3:`CTRL_LINK_CH_LSB]};
   wire        last     = (cur_cnt <= 16'h0001);
   wire        take     = active && minor_done;
   wire [31:0] src_step = modulo_wrap(src_addr, src_addr + sext16(step[15:0]), ctrl[4:0]);
   wire [31:0] dst_step = modulo_wrap(dst_addr, dst_addr + sext16(step[31:16]), ctrl[9:5]);
   wire        wr       = psel && penable && pwrite;
   wire        rd_ok;

   assign rd_ok = (paddr[11:6] == 6'h00) && (paddr[5:2] <= 4'hA) && (paddr[1:0] == 2'h0);

   desc_fetch #(.AW(32)) u_fetch (
      .pclk        (pclk),
      .presetn     (presetn),
      .start       (fetch_start),
      .base_addr   (sg_addr),
      .mem_req     (f_req),
      .mem_addr    (f_addr),
      .mem_ack     (mem_ack),
      .mem_rdata   (mem_rdata),
      .word_valid  (f_valid),
      .word_index  (f_idx),
      .word_data   (f_data),
      .busy        (f_busy),
      .align_error (f_aerr)
   );

   // ==========================================================
   // Channel sequencing
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_addr <= 32'h00000000;
         dst_addr <= 32'h00000000;
         step <= 32'h00000000;
         minor_ofs <= 32'h00000000;
         src_adj <= 32'h00000000;
         dst_adj <= 32'h00000000;
         iter <= `ITER_RESET;
         ctrl <= `CTRL_RESET;
         sg_addr <= 32'h00000000;
         done <= 1'b0;
         err <= 1'b0;
         req_en <= 1'b0;
         active <= 1'b0;
         fetch_start <= 1'b0;
         link_trigger <= 1'b0;
         link_channel <= {CHW{1'b0}};
         service_grant <= 1'b0;
         dma_error <= 1'b0;
      end else begin
         fetch_start <= 1'b0;
         link_trigger <= 1'b0;
         service_grant <= 1'b0;
         dma_error <= f_aerr;
         // Software writes
         if (wr) begin
            if (paddr == `OFF_SRC_ADDR) src_addr <= pwdata;
            else if (paddr == `OFF_DST_ADDR) dst_addr <= pwdata;
            else if (paddr == `OFF_STEP) step <= pwdata;
            else if (paddr == `OFF_MINOR_OFS) minor_ofs <= pwdata;
            else if (paddr == `OFF_SRC_ADJ) src_adj <= pwdata;
            else if (paddr == `OFF_DST_ADJ) dst_adj <= pwdata;
            else if (paddr == `OFF_ITER) iter <= pwdata;
            else if (paddr == `OFF_CTRL) begin
               // Link fields only accepted while done is clear
               ctrl <= done ? {pwdata[31:16], ctrl[15:10], pwdata[9:0]} : pwdata;
            end
            else if (paddr == `OFF_SG_ADDR) sg_addr <= pwdata;
            else if (paddr == `OFF_CMD) begin
               if (pwdata[`CMD_SET_REQ]) req_en <= 1'b1;
               if (pwdata[`CMD_CLR_REQ]) req_en <= 1'b0;
               if (pwdata[`CMD_CLR_DONE]) done <= 1'b0;
               if (pwdata[`CMD_CLR_ERR]) err <= 1'b0;
               if (pwdata[`CMD_SW_START] && !f_busy) active <= 1'b1;
            end
         end
         // Start a minor loop on request; blocked while a descriptor loads
         if (!active && !f_busy && !fetch_start && ((req_en && hw_req) || link_in)) begin
            active <= 1'b1;
            service_grant <= 1'b1;
         end
         // Minor loop end
         if (take) begin
            if (last) begin
               src_addr <= src_step + src_adj;
               dst_addr <= dst_step + dst_adj;
               iter[15:0] <= iter[31:16];
               done <= 1'b1;
               active <= 1'b0;
               if (lmode == `LINK_MAJOR || lmode == `LINK_MINOR) begin
                  link_trigger <= 1'b1;
                  link_channel <= link_ch;
               end
               if (ctrl[`CTRL_SG_EN]) begin
                  fetch_start <= 1'b1;
                  // Request enable kept so the next descriptor runs
               end else if (ctrl[`CTRL_AUTO_STOP]) begin
                  req_en <= 1'b0;
               end
            end else begin
               src_addr <= src_step + (minor_ofs[`MOFS_SRC_EN] ? mofs : 32'h00000000);
               dst_addr <= dst_step + (minor_ofs[`MOFS_DST_EN] ? mofs : 32'h00000000);
               iter[15:0] <= cur_cnt - 16'h0001;
               active <= 1'b0;
               if (lmode == `LINK_MINOR) begin
                  link_trigger <= 1'b1;
                  link_channel <= link_ch;
               end
            end
         end
         // Descriptor words land in the registers in layout order
         if (f_valid) begin
            case (f_idx)
               3'h0: src_addr <= f_data;
               3'h1: dst_addr <= f_data;
               3'h2: step <= f_data;
               3'h3: minor_ofs <= f_data;
               3'h4: src_adj <= f_data;
               3'h5: dst_adj <= f_data;
               3'h6: iter <= f_data;
               default: begin
                  ctrl <= f_data;
                  done <= 1'b0;
               end
            endcase
         end
         if (f_aerr) err <= 1'b1;
      end
   end

   // ==========================================================
   // APB slave, zero wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         cur_src <= 32'h00000000;
         cur_dst <= 32'h00000000;
         mem_req <= 1'b0;
         mem_addr <= 32'h00000000;
      end else begin
         cur_src <= src_addr;
         cur_dst <= dst_addr;
         mem_req <= f_req;
         mem_addr <= f_addr;
         pready <= psel && !penable;
         pslverr <= psel && !penable && !rd_ok;
         prdata <= 32'h00000000;
         if (psel && !penable && !pwrite) begin
            if (paddr == `OFF_SRC_ADDR) prdata <= src_addr;
            else if (paddr == `OFF_DST_ADDR) prdata <= dst_addr;
            else if (paddr == `OFF_STEP) prdata <= step;
            else if (paddr == `OFF_MINOR_OFS) prdata <= minor_ofs;
            else if (paddr == `OFF_SRC_ADJ) prdata <= src_adj;
            else if (paddr == `OFF_DST_ADJ) prdata <= dst_adj;
            else if (paddr == `OFF_ITER) prdata <= iter;
            else if (paddr == `OFF_CTRL) prdata <= ctrl;
            else if (paddr == `OFF_SG_ADDR) prdata <= sg_addr;
            else if (paddr == `OFF_STATUS) prdata <= {27'h0000000, f_busy, active, req_en, err, done};
         end
      end
   end
endmodule

//--- bench/dma_desc_monitor.sv
// Port checker for the channel descriptor logic
`timescale 1ns/1ns
module dma_desc_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        minor_done,
   input wire logic        service_grant,
   input wire logic        link_trigger,
   input wire logic        dma_error,
   input wire logic        mem_req,
   input wire logic [31:0] mem_addr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_access_ready: assert property (psel && penable |-> pready)
      else $error("no ready in access phase");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_link_cause: assert property (link_trigger |-> $past(minor_done) || $past(minor_done, 2))
      else $error("link without minor loop end");
   a_link_pulse: assert property (link_trigger |=> !link_trigger)
      else $error("link held too long");
   a_error_pulse: assert property (dma_error |=> !dma_error)
      else $error("error pulse held");
   a_error_no_fetch: assert property (dma_error |-> !mem_req)
      else $error("fetch after bad address");
   a_fetch_no_grant: assert property (mem_req |-> !service_grant)
      else $error("service during fetch");
   a_fetch_word: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
      else $error("fetch not word aligned");
endmodule
bind dma_channel_descriptor_logic dma_desc_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .minor_done(minor_done),
   .service_grant(service_grant), .link_trigger(link_trigger), .dma_error(dma_error),
   .mem_req(mem_req), .mem_addr(mem_addr));

//--- bench/desc_mem_model.sv
// Memory holding one stored descriptor, answering after LAT+1 cycles of request
`timescale 1ns/1ns
module desc_mem_model #(
   parameter LAT = 3
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        mem_req,
   input  wire logic [31:0] mem_addr,
   output logic             mem_ack,
   output logic [31:0]      mem_rdata
);
   int cnt;
   // Stored image uses the register order of the channel
   function automatic logic [31:0] word(input logic [2:0] k);
      return (k == 6) ? 32'h00020002 : (k == 7) ? 32'h00010000 : 32'h0000A000 + {27'h0, k, 2'b00};
   endfunction
   // Data bus toggles while idle so a stale word is never mistaken for an answer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt       <= 0;
         mem_ack   <= 1'b0;
         mem_rdata <= 32'h0;
      end else begin
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
         cnt       <= mem_req ? cnt + 1 : 0;
         if (mem_req && cnt == LAT) begin
            cnt       <= 0;
            mem_ack   <= 1'b1;
            mem_rdata <= word(mem_addr[4:2]);
         end
      end
   end
endmodule

//--- bench/dma_channel_descriptor_logic_tb.sv
// Self-checking bench for the channel descriptor logic
`timescale 1ns/1ns
`include "dma_desc_map.vh"
module dma_channel_descriptor_logic_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
   logic        hw_req, link_in, minor_done, service_grant, link_trigger, dma_error, mem_req, mem_ack;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, cur_src, cur_dst, mem_addr, mem_rdata, rd;
   logic [4:0]  link_channel;
   logic [31:0] exp_ch = 5;
   logic [31:0] es[3] = '{32'hF4, 32'hE8, 32'hFC};
   logic [31:0] ed[3] = '{32'h2FC, 32'h200, 32'h200};
   int          err_total = 0, total_checks = 0, link_cnt = 0, derr_cnt = 0, cyc = 0, m;
   dma_channel_descriptor_logic #(.CHW(5)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hw_req(hw_req), .link_in(link_in), .minor_done(minor_done),
      .service_grant(service_grant), .cur_src(cur_src), .cur_dst(cur_dst), .link_trigger(link_trigger),
      .link_channel(link_channel), .dma_error(dma_error), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   desc_mem_model #(.LAT(3)) mem_u (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   initial begin
      pclk = 0;
      forever #10 pclk = ~pclk;
   end
   // ==========================================
   // Tasks
   task chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task tally_and_finish;
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1, a, d);
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 0);
      chk(rd, e);
   endtask
   task run_loop;
      hw_req <= 1;
      do @(posedge pclk); while (service_grant !== 1'b1);
      hw_req <= 0;
      minor_done <= 1;
      @(posedge pclk);
      minor_done <= 0;
      repeat (4) @(posedge pclk);
   endtask
   function automatic logic [31:0] dword(input int k);
      return (k == 6) ? 32'h00020002 : (k == 7) ? 32'h00010000 : 32'h0000A000 + 4 * k;
   endfunction
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (link_trigger === 1'b1) begin
         link_cnt <= link_cnt + 1;
         chk({27'h0, link_channel}, exp_ch);
      end
      if (dma_error === 1'b1) begin
         derr_cnt <= derr_cnt + 1;
      end
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish;
      end
   end
   // ==========================================
   // Scenarios
   initial begin
      {psel, penable, pwrite, hw_req, link_in, minor_done} = 0;
      paddr = 0;
      pwdata = 0;
      presetn = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1;
      rdc(`OFF_ITER, `ITER_RESET);
      rdc(`OFF_CTRL, `CTRL_RESET);
      apb(0, 12'h030, 0);
      chk({31'h0, se}, 1);
      chk(rd, 0);
      wr(`OFF_SRC_ADDR, 32'h100);
      wr(`OFF_DST_ADDR, 32'h2F8);
      wr(`OFF_STEP, 32'h00040004);
      wr(`OFF_MINOR_OFS, 32'h800FFFF0);
      wr(`OFF_SRC_ADJ, 32'h10);
      wr(`OFF_DST_ADJ, 32'hFFFFFFFC);
      wr(`OFF_ITER, 32'h00030003);
      wr(`OFF_CTRL, 32'h00015500);
      wr(`OFF_CMD, 32'h1);
      for (int k = 0; k < 3; k++) begin
         run_loop;
         rdc(`OFF_SRC_ADDR, es[k]);
         rdc(`OFF_DST_ADDR, ed[k]);
         chk(cur_dst, ed[k]);
         chk(cur_src, es[k]);
         chk(link_cnt, k + 1);
      end
      rdc(`OFF_STATUS, 32'h1);
      rdc(`OFF_ITER, 32'h00030003);
      wr(`OFF_CMD, 32'h4);
      exp_ch = 3;
      wr(`OFF_CTRL, 32'h00013800);
      wr(`OFF_ITER, 32'h00020002);
      wr(`OFF_CMD, 32'h1);
      run_loop;
      chk(link_cnt, 3);
      run_loop;
      chk(link_cnt, 4);
      wr(`OFF_CMD, 32'h4);
      wr(`OFF_CTRL, 32'h00020000);
      wr(`OFF_ITER, 32'h00010001);
      wr(`OFF_SG_ADDR, 32'h104);
      wr(`OFF_CMD, 32'h1);
      run_loop;
      chk(derr_cnt, 1);
      rdc(`OFF_STATUS, 32'h7);
      wr(`OFF_CMD, 32'hC);
      wr(`OFF_SG_ADDR, 32'h40);
      run_loop;
      m = 0;
      do begin apb(0, `OFF_STATUS, 0); m++; end while (rd[4] !== 1'b0 && m < 40);
      rdc(`OFF_STATUS, 32'h4);
      for (int k = 0; k < 8; k++) begin
         rdc(12'(4 * k), dword(k));
      end
      wr(`OFF_CMD, 32'h2);
      rdc(`OFF_STATUS, 32'h0);
      wr(`OFF_CMD, 32'h10);
      rdc(`OFF_STATUS, 32'h8);
      tally_and_finish;
   end
endmodule
